// ### shared/ics_regs.vh
// Register map, command codes and field constants of the command sequencer
`ifndef ICS_REGS_VH
`define ICS_REGS_VH
// ==========================================
// Register offsets (byte addresses)
`define ICS_A_CMD      8'h00
`define ICS_A_STATUS   8'h04
`define ICS_A_SETUP    8'h08
`define ICS_A_OUTQ     8'h0C
`define ICS_A_IRQ_ST   8'h10
`define ICS_A_IRQ_MSK  8'h14
`define ICS_A_READING  8'h18
`define ICS_A_EVENT    8'h1C
// ==========================================
// Command codes, CMD register bits 3:0, slot in bits 5:4
`define ICS_C_OPC      4'h1
`define ICS_C_OPCQ     4'h2
`define ICS_C_SAV      4'h3
`define ICS_C_RCL      4'h4
`define ICS_C_RST      4'h5
`define ICS_C_TRG      4'h6
`define ICS_C_TST      4'h7
`define ICS_C_WAI      4'h8
`define ICS_C_CONF     4'h9
`define ICS_C_FETCH    4'hA
`define ICS_C_READ     4'hB
`define ICS_C_MEAS     4'hC
`define ICS_C_INIT     4'hD
`define ICS_C_ABORT    4'hE
`define ICS_C_PRESET   4'hF
`define ICS_CMD_W      4
`define ICS_SLOT_LSB   4
`define ICS_SLOT_MSB   5
// ==========================================
// Setup word fields
`define ICS_SETUP_W    16
`define ICS_F_ARMSRC   0
`define ICS_F_TRGSRC   1
`define ICS_F_MATH     2
`define ICS_F_BUFEN    3
`define ICS_F_AZERO    4
`define ICS_F_FUNC     5
`define ICS_F_ACNT_L   8
`define ICS_F_ACNT_H   11
`define ICS_F_TCNT_L   12
`define ICS_F_TCNT_H   15
`define ICS_RST_SETUP  16'h1110
`define ICS_PRE_SETUP  16'h1130
`define ICS_CONF_MASK  16'h00E0
`define ICS_CONF_SET   16'h1130
// ==========================================
// Output queue codes and misc
`define ICS_ASCII_ONE  8'h31
`define ICS_TST_PASS   8'h30
`define ICS_TST_FAIL   8'h31
`define ICS_Q_DEPTH    8
`define ICS_Q_AW       3
`define ICS_SLOTS      3
`define ICS_SLOT_MAX   2'h2
`define ICS_ESR_OPC    0
`define ICS_IRQ_OPC    0
`define ICS_IRQ_OUTQ   1
`define ICS_IRQ_RCLE   2
`define ICS_IRQ_W      3
`endif

// ### rtl/ics_setup_mem.v
// Three-slot setup store with registered read data
`timescale 1ns/100ps
`include "ics_regs.vh"
module ics_setup_mem
(
    // Clock and reset
    input  wire                       clk,
    input  wire                       arst_n,
    // Access
    input  wire                       wr_en,
    input  wire [1:0]                 addr,
    input  wire [`ICS_SETUP_W-1:0]    wdata,
    output reg  [`ICS_SETUP_W-1:0]    rdata_q
);
    reg [`ICS_SETUP_W-1:0] mem_q [0:`ICS_SLOTS-1];
    integer i;
    // ==========================================
    // Storage
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (i = 0; i < `ICS_SLOTS; i = i + 1)
                mem_q[i] <= `ICS_PRE_SETUP;
            rdata_q <= `ICS_PRE_SETUP;
        end
        else
        begin
            if (wr_en && addr <= `ICS_SLOT_MAX)
                mem_q[addr] <= wdata;
            if (addr <= `ICS_SLOT_MAX)
                rdata_q <= mem_q[addr];
            else
                rdata_q <= `ICS_PRE_SETUP;
        end
    end
endmodule

// ### rtl/ics_sequencer.v
// Command sequencer: hold queue, operation complete, setups, self-test
// Notes on behaviour
// - OPC sets completion event bit after all pending operations finish.
// - OPC query queues ASCII 1 after all pending operations finish.
// - While active, commands are held except clears, preset, reset, trigger, abort.
// - On return to idle, held commands run; completion after the last.
// - Three setup slots 0 to 2; save stores, recall restores.
// - Saved setup holds every control that reset defaults.
// - Failed recall loads preset values; slots start at preset values.
// - Reset restores defaults, drops pending commands and owed completion answers.
// - Trigger command equals bus trigger; honoured only with bus arm source.
// - Self-test checksums ROM, queues 0 pass or 1 fail.
// - Wait-to-continue does nothing.
// - Configure runs now if idle, else deferred until idle.
// - Configure sets function, immediate sources, counts one, math off, autozero on.
// - Fetch returns latest readings, no measurement, no setup change.
// - Read does initiate then fetch, waiting for idle first.
// - Measure runs configure then read, in order.
`timescale 1ns/100ps
`include "ics_regs.vh"
module ics_sequencer
(
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata_q,
    // Bus events (pins)
    input  wire        dev_clear_pin,
    input  wire        get_pin,
    input  wire        talk_pin,
    // Trigger model and measurement core
    input  wire        meas_done,
    input  wire        rom_sum_ok,
    input  wire [31:0] reading,
    output reg         init_pulse_q,
    output reg         abort_pulse_q,
    output reg         bus_trig_q,
    output reg         buf_abort_q,
    output reg  [15:0] setup_q,
    // Output queue to bus
    output reg  [7:0]  outq_data_q,
    output reg         outq_valid_q,
    // Interrupt
    output wire        irq
);
    // ==========================================
    // Pin synchronisers
    reg [1:0] dcl_s_q, get_s_q, talk_s_q;
    reg       get_d_q, talk_d_q;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dcl_s_q  <= 2'h0;
            get_s_q  <= 2'h0;
            talk_s_q <= 2'h0;
            get_d_q  <= 1'b0;
            talk_d_q <= 1'b0;
        end
        else
        begin
            dcl_s_q  <= {dcl_s_q[0], dev_clear_pin};
            get_s_q  <= {get_s_q[0], get_pin};
            talk_s_q <= {talk_s_q[0], talk_pin};
            get_d_q  <= get_s_q[1];
            talk_d_q <= talk_s_q[1];
        end
    end
    wire get_ev  = get_s_q[1] & ~get_d_q;
    wire talk_ev = talk_s_q[1] & ~talk_d_q;
    wire dcl     = dcl_s_q[1];

    // ==========================================
    // Command decode
    wire       cmd_wr   = wr && addr == `ICS_A_CMD;
    wire [3:0] cmd_in   = wdata[`ICS_CMD_W-1:0];
    wire [1:0] slot_in  = wdata[`ICS_SLOT_MSB:`ICS_SLOT_LSB];
    // immediate class, trigger acts like bus trigger
    wire       cmd_imm  = cmd_in == `ICS_C_RST || cmd_in == `ICS_C_ABORT ||
                          cmd_in == `ICS_C_PRESET || cmd_in == `ICS_C_TRG;
    reg        active_q;
    reg  [5:0] q_mem [0:`ICS_Q_DEPTH-1];
    reg  [2:0] wp_q, rp_q;
    reg  [3:0] cnt_q;
    wire       q_empty  = cnt_q == 4'h0;
    wire       q_full   = cnt_q == `ICS_Q_DEPTH;
    wire       hold     = cmd_wr && !cmd_imm && (active_q || !q_empty);
    reg        busy_q;
    wire       pop      = !active_q && !q_empty && !busy_q;
    wire       direct   = cmd_wr && !hold;
    wire [5:0] ex_word  = direct ? wdata[5:0] : q_mem[rp_q];
    wire       ex_go    = direct || pop;
    wire [3:0] ex_cmd   = ex_word[3:0];
    wire [1:0] ex_slot  = ex_word[5:4];
    wire       do_rst   = ex_go && ex_cmd == `ICS_C_RST;
    wire       flush    = do_rst || dcl;

    // ==========================================
    // Hold FIFO
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wp_q  <= 3'h0;
            rp_q  <= 3'h0;
            cnt_q <= 4'h0;
        end
        else if (flush)
        begin
            wp_q  <= 3'h0;
            rp_q  <= 3'h0;
            cnt_q <= 4'h0;
        end
        else
        begin
            if (hold && !q_full)
                wp_q <= wp_q + 3'h1;
            if (pop && !direct)
                rp_q <= rp_q + 3'h1;
            cnt_q <= cnt_q + {3'h0, hold && !q_full} - {3'h0, pop && !direct};
        end
    end
    always @(posedge clk)
    begin
        if (hold && !q_full)
            q_mem[wp_q] <= wdata[5:0];
    end

    // ==========================================
    // Execution
    reg         mem_wr;
    reg  [1:0]  mem_addr_q;
    wire [15:0] mem_rdata;
    reg         rcl_q, read_after_q, fetch_q;
    reg         opc_pend_q, opcq_pend_q;
    reg         esr_opc_q;
    reg  [31:0] reading_q;
    reg  [2:0]  irq_st_q, irq_msk_q;
    reg         rcl_err;
    wire        arm_bus = setup_q[`ICS_F_ARMSRC];
    wire        outq_pop = talk_ev && outq_valid_q;
    wire        rcl_bad = ex_go && ex_cmd == `ICS_C_RCL && ex_slot > `ICS_SLOT_MAX;
    always @*
    begin
        mem_wr  = ex_go && ex_cmd == `ICS_C_SAV && ex_slot <= `ICS_SLOT_MAX;
        rcl_err = rcl_bad;
    end

    ics_setup_mem u_mem
    (
        .clk    (clk),
        .arst_n (arst_n),
        .wr_en  (mem_wr),
        .addr   (ex_go ? ex_slot : mem_addr_q),
        .wdata  (setup_q),
        .rdata_q(mem_rdata)
    );

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            setup_q      <= `ICS_RST_SETUP;
            active_q     <= 1'b0;
            busy_q       <= 1'b0;
            rcl_q        <= 1'b0;
            read_after_q <= 1'b0;
            fetch_q      <= 1'b0;
            mem_addr_q   <= 2'h0;
            opc_pend_q   <= 1'b0;
            opcq_pend_q  <= 1'b0;
            esr_opc_q    <= 1'b0;
            init_pulse_q <= 1'b0;
            abort_pulse_q<= 1'b0;
            bus_trig_q   <= 1'b0;
            buf_abort_q  <= 1'b0;
            outq_data_q  <= 8'h00;
            outq_valid_q <= 1'b0;
            reading_q    <= 32'h0;
        end
        else
        begin
            init_pulse_q  <= 1'b0;
            abort_pulse_q <= 1'b0;
            bus_trig_q    <= 1'b0;
            buf_abort_q   <= 1'b0;
            rcl_q         <= 1'b0;
            busy_q        <= 1'b0;
            if (ex_go)
                mem_addr_q <= ex_slot;
            // Direct setup write; commands below take priority
            if (wr && addr == `ICS_A_SETUP)
                setup_q <= wdata[`ICS_SETUP_W-1:0];
            if (outq_pop)
                outq_valid_q <= 1'b0;
            if (meas_done)
            begin
                active_q  <= 1'b0;
                reading_q <= reading;
            end
            // bus trigger when arm source bus
            if (get_ev && arm_bus && active_q)
                bus_trig_q <= 1'b1;
            if (rcl_q)
                setup_q <= mem_rdata;
            if (fetch_q && !active_q)
            begin
                fetch_q      <= 1'b0;
                outq_data_q  <= reading_q[7:0];
                outq_valid_q <= 1'b1;
            end
            if (read_after_q && !active_q)
            begin
                read_after_q <= 1'b0;
                init_pulse_q <= 1'b1;
                active_q     <= 1'b1;
                fetch_q      <= 1'b1;
                busy_q       <= 1'b1;
            end
            // Software clear first, a completion in the same cycle wins
            if (wr && addr == `ICS_A_EVENT && wdata[`ICS_ESR_OPC])
                esr_opc_q <= 1'b0;
            if (!active_q && q_empty && !read_after_q && !fetch_q)
            begin
                if (opc_pend_q)
                    esr_opc_q <= 1'b1;
                if (opcq_pend_q)
                begin
                    outq_data_q  <= `ICS_ASCII_ONE;
                    outq_valid_q <= 1'b1;
                end
                opc_pend_q  <= 1'b0;
                opcq_pend_q <= 1'b0;
            end
            if (ex_go)
            begin
                case (ex_cmd)
                    `ICS_C_OPC:   opc_pend_q  <= 1'b1;
                    `ICS_C_OPCQ:  opcq_pend_q <= 1'b1;
                    `ICS_C_RCL:
                    begin
                        if (rcl_bad)
                            setup_q <= `ICS_PRE_SETUP;
                        else
                            rcl_q <= 1'b1;
                    end
                    `ICS_C_PRESET: setup_q <= `ICS_PRE_SETUP;
                    `ICS_C_TRG:
                    begin
                        if (arm_bus && active_q)
                            bus_trig_q <= 1'b1;
                    end
                    `ICS_C_TST:
                    begin
                        outq_data_q  <= rom_sum_ok ? `ICS_TST_PASS : `ICS_TST_FAIL;
                        outq_valid_q <= 1'b1;
                    end
                    `ICS_C_WAI:   busy_q <= 1'b0;
                    `ICS_C_CONF, `ICS_C_MEAS:
                    begin
                        setup_q     <= (setup_q & `ICS_CONF_MASK) | `ICS_CONF_SET;
                        active_q    <= 1'b0;
                        buf_abort_q <= setup_q[`ICS_F_BUFEN];
                        if (ex_cmd == `ICS_C_MEAS)
                            read_after_q <= 1'b1;
                    end
                    `ICS_C_FETCH: fetch_q      <= 1'b1;
                    `ICS_C_READ:  read_after_q <= 1'b1;
                    `ICS_C_INIT:
                    begin
                        init_pulse_q <= 1'b1;
                        active_q     <= 1'b1;
                    end
                    `ICS_C_ABORT:
                    begin
                        abort_pulse_q <= 1'b1;
                        active_q      <= 1'b0;
                    end
                    default:      busy_q <= 1'b0;
                endcase
            end
            // reset defaults and drop owed answers
            if (do_rst || dcl)
            begin
                setup_q      <= `ICS_RST_SETUP;
                active_q     <= 1'b0;
                opc_pend_q   <= 1'b0;
                opcq_pend_q  <= 1'b0;
                read_after_q <= 1'b0;
                fetch_q      <= 1'b0;
                abort_pulse_q<= 1'b1;
            end
        end
    end

    // ==========================================
    // Interrupt status, set wins over clear
    wire [2:0] irq_set = {rcl_err, fetch_q && !active_q,
                          (opc_pend_q && !active_q && q_empty && !read_after_q && !fetch_q)};
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_st_q  <= 3'h0;
            irq_msk_q <= 3'h0;
        end
        else
        begin
            if (wr && addr == `ICS_A_IRQ_MSK)
                irq_msk_q <= wdata[`ICS_IRQ_W-1:0];
            irq_st_q <= (irq_st_q & ~((wr && addr == `ICS_A_IRQ_ST) ? wdata[`ICS_IRQ_W-1:0] : 3'h0))
                        | irq_set;
        end
    end
    assign irq = |(irq_st_q & irq_msk_q);

    // ==========================================
    // Read port
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 32'h0;
        else if (rd)
        begin
            case (addr)
                `ICS_A_STATUS:  rdata_q <= {24'h0, cnt_q, opcq_pend_q, opc_pend_q, q_full, active_q};
                `ICS_A_SETUP:   rdata_q <= {16'h0, setup_q};
                `ICS_A_OUTQ:    rdata_q <= {23'h0, outq_valid_q, outq_data_q};
                `ICS_A_IRQ_ST:  rdata_q <= {29'h0, irq_st_q};
                `ICS_A_IRQ_MSK: rdata_q <= {29'h0, irq_msk_q};
                `ICS_A_READING: rdata_q <= reading_q;
                `ICS_A_EVENT:   rdata_q <= {31'h0, esr_opc_q};
                default:        rdata_q <= 32'h0;
            endcase
        end
        else
            rdata_q <= 32'h0;
    end
endmodule

// ### sim/ics_seq_props.sv
// Port-level assertion checker for the command sequencer
`timescale 1ns/100ps
`include "ics_regs.vh"
module ics_seq_props
(
    // Clock, reset and register port
    input wire        clk,
    input wire        arst_n,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata_q,
    // Bus pins and measurement core
    input wire        dev_clear_pin,
    input wire        get_pin,
    input wire        talk_pin,
    input wire        meas_done,
    input wire        rom_sum_ok,
    input wire [31:0] reading,
    input wire        init_pulse_q,
    input wire        abort_pulse_q,
    input wire        bus_trig_q,
    input wire        buf_abort_q,
    input wire [15:0] setup_q,
    input wire [7:0]  outq_data_q,
    input wire        outq_valid_q,
    input wire        irq
);
// ==========================================
// Command decode
default clocking dc @(posedge clk); endclocking
default disable iff (!arst_n);
wire       is_cmd = wr && (addr == `ICS_A_CMD);
wire [3:0] code   = wdata[3:0];
// ==========================================
// Properties; recall checks assume an idle device
AST_RST_DEF: assert property (is_cmd && code == `ICS_C_RST |=> setup_q == `ICS_RST_SETUP)
    else $error("reset command left setup");
AST_ABORT_NOW: assert property (is_cmd && code == `ICS_C_ABORT |=> abort_pulse_q)
    else $error("abort not acted on");
AST_PRESET: assert property (is_cmd && code == `ICS_C_PRESET |=> setup_q == `ICS_PRE_SETUP)
    else $error("preset values missing");
AST_RD_ONLY: assert property (!$past(rd) |-> rdata_q == 32'h0000_0000)
    else $error("read data outside its cycle");
AST_TRG_ARM: assert property (bus_trig_q |-> setup_q[`ICS_F_ARMSRC])
    else $error("bus trigger without bus arm source");
AST_POP: assert property (outq_valid_q && $rose(talk_pin) |-> ##[1:4] !outq_valid_q)
    else $error("output byte not released");
AST_DCL: assert property ($rose(dev_clear_pin) |-> ##[2:5] setup_q == `ICS_RST_SETUP)
    else $error("device clear ignored");
AST_FETCH_KEEP: assert property (is_cmd && code == `ICS_C_FETCH |=> ($stable(setup_q))[*3])
    else $error("fetch changed setup");
AST_WAI_NOP: assert property (is_cmd && code == `ICS_C_WAI |=> ($stable(setup_q) && !init_pulse_q)[*2])
    else $error("wait command had an effect");
AST_RCL_BAD: assert property (is_cmd && code == `ICS_C_RCL && wdata[5:4] == 2'h3
    |-> ##[1:3] setup_q == `ICS_PRE_SETUP)
    else $error("failed recall kept setup");
endmodule
bind ics_sequencer ics_seq_props u_props
(
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .dev_clear_pin(dev_clear_pin), .get_pin(get_pin), .talk_pin(talk_pin), .meas_done(meas_done),
    .rom_sum_ok(rom_sum_ok), .reading(reading), .init_pulse_q(init_pulse_q),
    .abort_pulse_q(abort_pulse_q), .bus_trig_q(bus_trig_q), .buf_abort_q(buf_abort_q),
    .setup_q(setup_q), .outq_data_q(outq_data_q), .outq_valid_q(outq_valid_q), .irq(irq)
);

// ### sim/ics_meas_model.sv
// Measurement core stand-in: ends a run a fixed time after start
`timescale 1ns/100ps
module ics_meas_model
#(
    parameter [7:0] DLY = 8'h14
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Run control
    input  wire        start,
    input  wire        stop,
    // Completion and data
    output reg         meas_done,
    output reg  [31:0] reading
);
reg [7:0] cnt_q;
// Fresh reading each run, so a stale fetch is visible
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        cnt_q <= 8'h00;
        meas_done <= 1'b0;
        reading <= 32'h0000_0040;
    end
    else
    begin
        meas_done <= (cnt_q == 8'h01);
        if (cnt_q == 8'h01)
            reading <= reading + 32'h0000_0001;
        if (stop)
            cnt_q <= 8'h00;
        else if (start)
            cnt_q <= DLY;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
end
endmodule

// ### sim/test_instrument_command_sequencer.sv
// Self-checking bench of the command sequencer
`timescale 1ns/100ps
`include "ics_regs.vh"
module test_instrument_command_sequencer;
reg         clk = 0, arst_n = 0, wr = 0, rd = 0;
reg         dev_clear_pin = 0, get_pin = 0, talk_pin = 0, rom_sum_ok = 1;
reg  [7:0]  addr = 0;
reg  [31:0] wdata = 0;
wire [31:0] rdata_q, reading;
wire [15:0] setup_q;
wire [7:0]  outq_data_q;
wire        meas_done, init_pulse_q, abort_pulse_q, bus_trig_q, buf_abort_q, outq_valid_q, irq;
integer     fail_count = 0, n_tests = 0, cyc = 0, n_init = 0, n_trig = 0, n_buf = 0, i;
always #25 clk = ~clk;
ics_sequencer dut_u
(
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .dev_clear_pin(dev_clear_pin), .get_pin(get_pin), .talk_pin(talk_pin), .meas_done(meas_done),
    .rom_sum_ok(rom_sum_ok), .reading(reading), .init_pulse_q(init_pulse_q),
    .abort_pulse_q(abort_pulse_q), .bus_trig_q(bus_trig_q), .buf_abort_q(buf_abort_q), .setup_q(setup_q),
    .outq_data_q(outq_data_q), .outq_valid_q(outq_valid_q), .irq(irq)
);
ics_meas_model #(.DLY(8'h14)) model_u
(
    .clk(clk), .arst_n(arst_n), .start(init_pulse_q), .stop(abort_pulse_q),
    .meas_done(meas_done), .reading(reading)
);
// ==========================================
// Monitors and hang guard
always @(posedge clk)
begin
    cyc = cyc + 1;
    n_init = n_init + init_pulse_q;
    n_trig = n_trig + bus_trig_q;
    n_buf = n_buf + buf_abort_q;
    if (cyc == 5000)
    begin
        fail_count = fail_count + 1;
        give_verdict;
    end
end
// ==========================================
// Bus tasks and compare
task give_verdict;
begin
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
end
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
    end
end
endtask
task tick(input integer n);
begin
    repeat (n) @(posedge clk);
    #1;
end
endtask
task wr_reg(input [7:0] a, input [31:0] d);
begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
end
endtask
task rd_chk(input [7:0] a, input [31:0] m, input [31:0] exp);
begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    chk(rdata_q & m, exp);
end
endtask
task cmd(input [3:0] c, input [1:0] s);
    wr_reg(`ICS_A_CMD, {26'h0, s, c});
endtask
// Host takes the byte only when addressed to talk
task pop;
begin
    talk_pin <= 1'b1;
    tick(3);
    talk_pin <= 1'b0;
    tick(5);
end
endtask
// ==========================================
// Scenarios
initial
begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    tick(1);
    chk(setup_q, `ICS_RST_SETUP);
    rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0);
    cmd(`ICS_C_RCL, 2'h1);
    tick(3);
    chk(setup_q, `ICS_PRE_SETUP);
    cmd(`ICS_C_RST, 2'h0);
    cmd(`ICS_C_SAV, 2'h2);
    cmd(`ICS_C_PRESET, 2'h0);
    cmd(`ICS_C_RCL, 2'h2);
    tick(3);
    chk(setup_q, `ICS_RST_SETUP);
    cmd(`ICS_C_RCL, 2'h3);
    tick(3);
    chk({irq, setup_q}, {1'b0, `ICS_PRE_SETUP});
    wr_reg(`ICS_A_IRQ_MSK, 32'h4);
    tick(1);
    chk(irq, 1'b1);
    wr_reg(`ICS_A_IRQ_ST, 32'h4);
    tick(1);
    chk(irq, 1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
        rom_sum_ok <= (i == 0);
        cmd(`ICS_C_TST, 2'h0);
        tick(3);
        chk({outq_valid_q, outq_data_q}, {1'b1, i ? `ICS_TST_FAIL : `ICS_TST_PASS});
        pop;
        chk(outq_valid_q, 1'b0);
    end
    cmd(`ICS_C_RST, 2'h0);
    cmd(`ICS_C_WAI, 2'h0);
    tick(3);
    chk({outq_valid_q, setup_q}, {1'b0, `ICS_RST_SETUP});
    // Held while measuring, run in order at idle
    cmd(`ICS_C_INIT, 2'h0);
    cmd(`ICS_C_OPCQ, 2'h0);
    cmd(`ICS_C_OPC, 2'h0);
    cmd(`ICS_C_CONF, 2'h0);
    tick(3);
    chk({outq_valid_q, setup_q}, {1'b0, `ICS_RST_SETUP});
    rd_chk(`ICS_A_EVENT, 32'h1, 32'h0);
    tick(30);
    rd_chk(`ICS_A_EVENT, 32'h1, 32'h1);
    chk({outq_valid_q, outq_data_q}, {1'b1, `ICS_ASCII_ONE});
    chk(setup_q, `ICS_CONF_SET);
    rd_chk(`ICS_A_IRQ_ST, 32'h3, 32'h1);
    pop;
    wr_reg(`ICS_A_EVENT, 32'h1);
    // Reset in mid-run drops owed answers
    cmd(`ICS_C_INIT, 2'h0);
    cmd(`ICS_C_OPCQ, 2'h0);
    cmd(`ICS_C_OPC, 2'h0);
    cmd(`ICS_C_RST, 2'h0);
    tick(30);
    chk({outq_valid_q, setup_q}, {1'b0, `ICS_RST_SETUP});
    rd_chk(`ICS_A_EVENT, 32'h1, 32'h0);
    cmd(`ICS_C_TRG, 2'h0);
    get_pin <= 1'b1;
    tick(8);
    get_pin <= 1'b0;
    chk(n_trig, 0);
    // Counts are one here, so a read is allowed
    cmd(`ICS_C_MEAS, 2'h0);
    tick(5);
    chk({n_init[15:0], setup_q}, {16'h3, `ICS_CONF_SET});
    tick(30);
    chk({outq_valid_q, outq_data_q}, {1'b1, reading[7:0]});
    pop;
    cmd(`ICS_C_FETCH, 2'h0);
    tick(3);
    chk({outq_valid_q, outq_data_q}, {1'b1, reading[7:0]});
    chk(n_init, 3);
    rd_chk(`ICS_A_IRQ_ST, 32'h2, 32'h2);
    pop;
    cmd(`ICS_C_INIT, 2'h0);
    cmd(`ICS_C_READ, 2'h0);
    tick(3);
    chk(n_init, 4);
    tick(30);
    chk(n_init, 5);
    tick(30);
    chk({outq_valid_q, outq_data_q}, {1'b1, reading[7:0]});
    pop;
    dev_clear_pin <= 1'b1;
    tick(6);
    dev_clear_pin <= 1'b0;
    chk(setup_q, `ICS_RST_SETUP);
    // Let the clear leave the synchroniser before the setup write
    tick(3);
    // Bus arm source: command and pin both trigger while measuring
    wr_reg(`ICS_A_SETUP, 32'h0000_1119);
    cmd(`ICS_C_INIT, 2'h0);
    cmd(`ICS_C_TRG, 2'h0);
    get_pin <= 1'b1;
    tick(8);
    get_pin <= 1'b0;
    chk(n_trig, 2);
    cmd(`ICS_C_ABORT, 2'h0);
    tick(3);
    rd_chk(`ICS_A_STATUS, 32'h1, 32'h0);
    cmd(`ICS_C_CONF, 2'h0);
    tick(3);
    chk({n_buf[15:0], setup_q}, {16'h1, `ICS_CONF_SET});
    give_verdict;
end
endmodule
